// ### rtl/det_trim_pkg.sv
// What this block does
// - I-path LO phase trim from 0x05[3:0]
// - Q-path LO phase trim from 0x05[7:4]
// - distortion cancel trim from 0x04[7:0]
// - detector shown on pin and serial readback
// - result valid only with converter controls set
// - conversion starts on falling start bit
// - frame is rw, 6 address, 16 data, parity
package det_trim_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [5:0] ADDR_POWER_CTRL = 6'h03;
    localparam logic [5:0] ADDR_LIN_TRIM = 6'h04;
    localparam logic [5:0] ADDR_LO_QUAD = 6'h05;
    localparam logic [5:0] ADDR_CONV_CTRL = 6'h06;
    localparam logic [5:0] ADDR_CONV_RESULT = 6'h0c;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] RST_POWER_CTRL = 16'h0157;
    localparam logic [15:0] RST_LIN_TRIM = 16'h0080;
    localparam logic [15:0] RST_LO_QUAD = 16'h0000;
    localparam logic [15:0] RST_CONV_CTRL = 16'h0000;
    localparam logic [7:0] RST_RESULT_VAL = 8'h10;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int LO_DIRECT_BIT = 2;
    localparam int LO_DOUBLER_BIT = 3;
    localparam int DET_ON_BIT = 7;
    localparam int CONV_CLK_BIT = 0;
    localparam int CONV_ON_BIT = 1;
    localparam int CONV_START_BIT = 2;
    localparam int PIN_SEL_BIT = 3;
    localparam int READY_BIT = 8;

    // ************************************************************
    // serial frame layout
    // ************************************************************
    localparam logic [4:0] HDR_LAST_BIT = 5'h06;
    localparam logic [4:0] HDR_BITS = 5'h07;
    localparam logic [4:0] DATA_END_BIT = 5'h17;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_FREQ_MHZ = 100;
    localparam int CONV_TIME_US = 200;
    localparam int CONV_CYCLES = CONV_TIME_US * CLK_FREQ_MHZ;

    // converter sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } conv_state_e;
endpackage

// ### rtl/detector_adc_trim.sv
module detector_adc_trim #(
    parameter int CONV_CYCLES = det_trim_pkg::CONV_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial port
    input wire logic sclk,
    input wire logic sdin,
    input wire logic senN,
    output logic sdtoOut,
    output logic sdtoOe,
    // digitised detector code from the analog converter
    input wire logic [7:0] detCode,
    // trim outputs to the analog core
    output logic [3:0] iPhaseTrim,
    output logic [3:0] qPhaseTrim,
    output logic [7:0] distortion_cancel_trim,
    // power and mode controls
    output logic detectorOn,
    output logic lo_doubler_on,
    output logic lo_direct_on,
    output logic converterOn,
    output logic converterClkOn,
    output logic convBusy,
    output logic det_voltage_pin
);
    // ************************************************************
    // elaboration check
    // ************************************************************
    if (CONV_CYCLES < 1 || CONV_CYCLES > 1048575) begin : g_bad_cycles
        $error("CONV_CYCLES must lie in 1..1048575");
    end

    localparam logic [19:0] CNT_LAST = 20'(CONV_CYCLES - 1);

    // ************************************************************
    // registers and state
    // ************************************************************
    logic [15:0] powerCtrl_q; // block_power_ctrl
    logic [15:0] linTrim_q;   // linearity_trim
    logic [15:0] loQuad_q;    // lo_quadrature_trim
    logic [15:0] convCtrl_q;  // detector_conv_ctrl
    logic [7:0] resultVal_q;  // held detector result
    logic ready_q;            // result ready flag
    logic startPrev_q;        // start bit one cycle ago
    logic pinOn_q;            // detector level routed to its pin
    logic [19:0] convCnt_q;   // cycles into the conversion
    det_trim_pkg::conv_state_e state_q;
    logic convEnabled;        // detector, converter and clock all on
    logic startFell;          // start bit written high then low

    reg_access_if bus ();

    // serial front end
    serial_frame_port u_port (
        .clk(clk),
        .rst(rst),
        .sclk(sclk),
        .sdin(sdin),
        .senN(senN),
        .sdtoOut_q(sdtoOut),
        .sdtoOe_q(sdtoOe),
        .bus(bus.port)
    );

    assign convEnabled = powerCtrl_q[det_trim_pkg::DET_ON_BIT] &&
                         convCtrl_q[det_trim_pkg::CONV_ON_BIT] &&
                         convCtrl_q[det_trim_pkg::CONV_CLK_BIT];
    assign startFell = startPrev_q &&
                       !convCtrl_q[det_trim_pkg::CONV_START_BIT];

    // outputs are plain slices of the register flops, except busy (state_q) and the pin (pinOn_q)
    assign iPhaseTrim = loQuad_q[3:0];
    assign qPhaseTrim = loQuad_q[7:4];
    assign distortion_cancel_trim = linTrim_q[7:0];
    assign detectorOn = powerCtrl_q[det_trim_pkg::DET_ON_BIT];
    assign lo_doubler_on = powerCtrl_q[det_trim_pkg::LO_DOUBLER_BIT];
    assign lo_direct_on = powerCtrl_q[det_trim_pkg::LO_DIRECT_BIT];
    assign converterOn = convCtrl_q[det_trim_pkg::CONV_ON_BIT];
    assign converterClkOn = convCtrl_q[det_trim_pkg::CONV_CLK_BIT];
    assign convBusy = state_q[1];
    assign det_voltage_pin = pinOn_q;

    // ************************************************************
    // register writes
    // ************************************************************
    // writable registers; reserved bits are kept as written.
    // the mode bits are not policed: doubler and direct may both be set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            powerCtrl_q <= det_trim_pkg::RST_POWER_CTRL;
            linTrim_q <= det_trim_pkg::RST_LIN_TRIM;
            loQuad_q <= det_trim_pkg::RST_LO_QUAD;
            convCtrl_q <= det_trim_pkg::RST_CONV_CTRL;
        end else if (bus.wrStb) begin
            case (bus.addr)
                det_trim_pkg::ADDR_POWER_CTRL: begin
                    powerCtrl_q <= bus.wrData;
                end
                det_trim_pkg::ADDR_LIN_TRIM: begin
                    linTrim_q <= bus.wrData;
                end
                det_trim_pkg::ADDR_LO_QUAD: begin
                    loQuad_q <= bus.wrData;
                end
                det_trim_pkg::ADDR_CONV_CTRL: begin
                    convCtrl_q <= bus.wrData;
                end
                default: begin
                    // result register and unmapped: write ignored
                end
            endcase
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    // result byte reads zero unless the converter is powered and
    // clocked; status is always visible so the host can poll it
    always_comb begin
        case (bus.addr)
            det_trim_pkg::ADDR_POWER_CTRL: bus.rdData = powerCtrl_q;
            det_trim_pkg::ADDR_LIN_TRIM: bus.rdData = linTrim_q;
            det_trim_pkg::ADDR_LO_QUAD: bus.rdData = loQuad_q;
            det_trim_pkg::ADDR_CONV_CTRL: bus.rdData = convCtrl_q;
            det_trim_pkg::ADDR_CONV_RESULT: begin
                bus.rdData = {7'h00, ready_q, 8'h00};
                if (converterOn && converterClkOn) begin
                    bus.rdData[7:0] = resultVal_q;
                end
            end
            default: bus.rdData = 16'h0000;
        endcase
    end

    // ************************************************************
    // detector pin routing
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinOn_q <= 1'b0;
        end else begin
            pinOn_q <= powerCtrl_q[det_trim_pkg::DET_ON_BIT] &&
                       convCtrl_q[det_trim_pkg::PIN_SEL_BIT];
        end
    end

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    // start edge tracker
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            startPrev_q <= 1'b0;
        end else begin
            startPrev_q <= convCtrl_q[det_trim_pkg::CONV_START_BIT];
        end
    end

    // a falling start launches a conversion; dropping any enable
    // aborts it and leaves the old result in place
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= det_trim_pkg::ST_IDLE;
            convCnt_q <= 20'h0_0000;
            ready_q <= 1'b0;
            resultVal_q <= det_trim_pkg::RST_RESULT_VAL;
        end else begin
            case (state_q)
                det_trim_pkg::ST_IDLE: begin
                    if (startFell && convEnabled) begin
                        state_q <= det_trim_pkg::ST_CONV;
                        convCnt_q <= 20'h0_0000;
                        ready_q <= 1'b0;
                    end
                end
                det_trim_pkg::ST_CONV: begin
                    if (!convEnabled) begin
                        state_q <= det_trim_pkg::ST_IDLE;
                    end else if (convCnt_q == CNT_LAST) begin
                        // only place the result changes
                        state_q <= det_trim_pkg::ST_IDLE;
                        resultVal_q <= detCode;
                        ready_q <= 1'b1;
                    end else begin
                        convCnt_q <= convCnt_q + 20'h0_0001;
                    end
                end
                default: begin
                    state_q <= det_trim_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_i_phase_trim: assert property (
        bus.wrStb && bus.addr == det_trim_pkg::ADDR_LO_QUAD
        |=> iPhaseTrim == $past(bus.wrData[3:0]))
        else $error("I-path trim did not follow write");
    a_q_phase_trim: assert property (
        bus.wrStb && bus.addr == det_trim_pkg::ADDR_LO_QUAD
        |=> qPhaseTrim == $past(bus.wrData[7:4]))
        else $error("Q-path trim did not follow write");
    a_distortion_trim: assert property (
        bus.wrStb && bus.addr == det_trim_pkg::ADDR_LIN_TRIM
        |=> distortion_cancel_trim == $past(bus.wrData[7:0]))
        else $error("distortion trim did not follow write");
    a_pin_route: assert property (
        detectorOn && convCtrl_q[det_trim_pkg::PIN_SEL_BIT]
        |=> det_voltage_pin)
        else $error("detector pin not routed");
    a_result_gated: assert property (
        bus.addr == det_trim_pkg::ADDR_CONV_RESULT &&
        !(converterOn && converterClkOn) |-> bus.rdData[7:0] == 8'h00)
        else $error("result visible with converter off");
    a_start_on_fall: assert property (
        !convBusy && startFell && convEnabled |=> convBusy && !ready_q)
        else $error("falling start did not launch conversion");
    a_no_start_high: assert property (
        !convBusy && !startFell |=> !convBusy)
        else $error("conversion began without falling start");
    a_result_hold: assert property (
        state_q != det_trim_pkg::ST_CONV |=> $stable(resultVal_q))
        else $error("result changed outside completion");
    a_conv_length: assert property (
        $rose(ready_q) |-> $past(convCnt_q) == CNT_LAST &&
        resultVal_q == $past(detCode))
        else $error("conversion length or capture wrong");

    c_conv_done: cover property ($rose(ready_q));
    c_conv_abort: cover property (convBusy && !convEnabled);
    c_result_read: cover property (
        ready_q && bus.addr == det_trim_pkg::ADDR_CONV_RESULT);
endmodule

// ### rtl/reg_access_if.sv
// carries decoded register accesses from the serial port to the regs
interface reg_access_if;
    logic wrStb;          // one-cycle write pulse
    logic [5:0] addr;     // address of current frame
    logic [15:0] wrData;  // write data, valid with wrStb
    logic [15:0] rdData;  // read data for addr, combinational

    modport port (output wrStb, output addr, output wrData,
                  input rdData);
    modport regs (input wrStb, input addr, input wrData,
                  output rdData);
endinterface

// ### rtl/serial_frame_port.sv
module serial_frame_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial pins, sampled on clk
    input wire logic sclk,
    input wire logic sdin,
    input wire logic senN,
    output logic sdtoOut_q,
    output logic sdtoOe_q,
    // register side
    reg_access_if.port bus
);
    // ************************************************************
    // edge detection on the serial clock
    // ************************************************************
    logic sclkPrev_q;     // sclk one cycle ago
    logic rise;           // sclk rising edge
    logic fall;           // sclk falling edge
    logic [4:0] bitCnt_q; // bits taken this frame
    logic [22:0] shift_q; // rw, address and data as received
    logic isRead_q;       // frame is a read
    logic [5:0] addr_q;   // latched address
    logic [15:0] rdShift_q; // remaining read bits plus parity
    logic wrStb_q;
    logic [15:0] wrData_q;
    logic rdParity;       // odd parity over the whole read frame

    assign rise = sclk & ~sclkPrev_q;
    assign fall = ~sclk & sclkPrev_q;
    assign rdParity = ~(^{isRead_q, addr_q, bus.rdData});
    assign bus.wrStb = wrStb_q;
    assign bus.addr = addr_q;
    assign bus.wrData = wrData_q;

    // previous sclk level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= sclk;
        end
    end

    // ************************************************************
    // receive path
    // ************************************************************
    // bit counter and shifter; a frame ends whenever enable rises
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bitCnt_q <= 5'h00;
            shift_q <= 23'h00_0000;
        end else if (senN) begin
            bitCnt_q <= 5'h00;
        end else if (rise && bitCnt_q < det_trim_pkg::FRAME_BITS) begin
            shift_q <= {shift_q[21:0], sdin};
            bitCnt_q <= bitCnt_q + 5'h01;
        end
    end

    // header capture on the last address bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_q <= 6'h00;
            isRead_q <= 1'b0;
        end else if (!senN && rise &&
                     bitCnt_q == det_trim_pkg::HDR_LAST_BIT) begin
            addr_q <= {shift_q[4:0], sdin};
            isRead_q <= shift_q[5];
        end
    end

    // write commits when the parity bit arrives; parity is not checked
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrStb_q <= 1'b0;
            wrData_q <= 16'h0000;
        end else begin
            wrStb_q <= !senN && rise && !isRead_q &&
                       bitCnt_q == det_trim_pkg::DATA_END_BIT;
            if (!senN && rise && bitCnt_q == det_trim_pkg::DATA_END_BIT)
            begin
                wrData_q <= shift_q[15:0];
            end
        end
    end

    // ************************************************************
    // read path, driven after falling edges, msb first then parity
    // ************************************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdtoOut_q <= 1'b0;
            sdtoOe_q <= 1'b0;
            rdShift_q <= 16'h0000;
        end else if (senN) begin
            sdtoOe_q <= 1'b0;
            sdtoOut_q <= 1'b0;
        end else if (fall && isRead_q &&
                     bitCnt_q == det_trim_pkg::HDR_BITS) begin
            // read data is sampled here, so it cannot tear mid-frame
            sdtoOe_q <= 1'b1;
            sdtoOut_q <= bus.rdData[15];
            rdShift_q <= {bus.rdData[14:0], rdParity};
        end else if (fall && sdtoOe_q &&
                     bitCnt_q < det_trim_pkg::FRAME_BITS) begin
            sdtoOut_q <= rdShift_q[15];
            rdShift_q <= {rdShift_q[14:0], 1'b0};
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_write_frame_len: assert property (
        wrStb_q |-> $past(bitCnt_q) == det_trim_pkg::DATA_END_BIT)
        else $error("write strobe not on the 24th bit");
    a_read_first_bit: assert property (
        $rose(sdtoOe_q) |-> sdtoOut_q == $past(bus.rdData[15]) &&
        isRead_q)
        else $error("read did not start with data msb");
    c_write_frame: cover property (wrStb_q);
    c_read_frame: cover property ($rose(sdtoOe_q));
endmodule

// ### tb/detector_adc_and_trim_control_tb_top.sv
// ************************************************************
// self-checking bench
// ************************************************************
module detector_adc_and_trim_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int CONV_N = 400; // short conversion, long enough to poll
    localparam int LIMIT = 20000; // cycle ceiling for the whole run

    logic clk, rst; // clock and reset
    logic [7:0] detCode; // converter code fed to the block
    wire sclk, sdin, senN, sdtoOut, sdtoOe; // serial pins
    wire [3:0] iPhaseTrim, qPhaseTrim; // phase trims
    wire [7:0] distortion_cancel_trim; // linearity trim
    wire detectorOn, lo_doubler_on, lo_direct_on; // mode controls
    wire converterOn, converterClkOn, convBusy, det_voltage_pin;
    int n_mismatch = 0; // mismatches seen
    int checks_done = 0; // comparisons made
    int cycles = 0; // cycles since start

    detector_adc_trim #(.CONV_CYCLES(CONV_N)) detector_adc_trim_i (
        .clk(clk), .rst(rst), .sclk(sclk), .sdin(sdin), .senN(senN),
        .sdtoOut(sdtoOut), .sdtoOe(sdtoOe), .detCode(detCode),
        .iPhaseTrim(iPhaseTrim), .qPhaseTrim(qPhaseTrim),
        .distortion_cancel_trim(distortion_cancel_trim),
        .detectorOn(detectorOn), .lo_doubler_on(lo_doubler_on),
        .lo_direct_on(lo_direct_on), .converterOn(converterOn),
        .converterClkOn(converterClkOn), .convBusy(convBusy),
        .det_voltage_pin(det_voltage_pin));

    serial_host_model serial_host_model_i (
        .clk(clk), .sclk(sclk), .sdin(sdin), .senN(senN),
        .sdtoOut(sdtoOut), .sdtoOe(sdtoOe));

    // 100 MHz clock
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    // hang guard: a run that overstays counts as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            final_report();
        end
    end

    // ************************************************************
    // compare helpers
    // ************************************************************
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read a register, compare it and its odd parity
    task automatic read_expect(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        logic p;
        serial_host_model_i.read_reg(a, d, p);
        check_val(d, e);
        check_bit(^{1'h1, a, d, p}, 1'h1);
        // the out line must be released once enable has gone high
        check_bit(sdtoOe, 1'h0);
    endtask

    // wait, bounded, for the busy flag to reach a level
    task automatic wait_busy(input logic lvl, input int lim);
        for (int n = 0; n < lim && convBusy !== lvl; n++) @(negedge clk);
        check_bit(convBusy, lvl);
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        serial_host_model_i.write_reg(a, d);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic test_reset();
        read_expect(det_trim_pkg::ADDR_POWER_CTRL, 16'h0157);
        read_expect(det_trim_pkg::ADDR_LIN_TRIM, 16'h0080);
        read_expect(det_trim_pkg::ADDR_LO_QUAD, 16'h0000);
        read_expect(det_trim_pkg::ADDR_CONV_CTRL, 16'h0000);
        // converter off: value byte gated, ready low
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h0000);
        check_bit(lo_direct_on, 1'h1);
        check_val({8'h00, distortion_cancel_trim}, 16'h0080);
        $display("test_reset done");
    endtask

    task automatic test_trims();
        wr(det_trim_pkg::ADDR_LO_QUAD, 16'h00A5);
        check_val({12'h000, iPhaseTrim}, 16'h0005);
        check_val({12'h000, qPhaseTrim}, 16'h000A);
        wr(det_trim_pkg::ADDR_LIN_TRIM, 16'h00FF);
        check_val({8'h00, distortion_cancel_trim}, 16'h00FF);
        read_expect(det_trim_pkg::ADDR_LO_QUAD, 16'h00A5);
        // result register is read-only, unmapped reads as zero
        wr(det_trim_pkg::ADDR_CONV_RESULT, 16'hFFFF);
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h0000);
        read_expect(6'h3F, 16'h0000);
        $display("test_trims done");
    endtask

    task automatic test_conversion();
        detCode <= 8'h5A;
        // doubler on with direct off, as for a carrier above 14 GHz;
        // detector on first
        wr(det_trim_pkg::ADDR_POWER_CTRL, 16'h01DB);
        check_bit(lo_doubler_on, 1'h1);
        check_bit(lo_direct_on, 1'h0);
        check_bit(detectorOn, 1'h1);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0002);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0003);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0007);
        check_bit(convBusy, 1'h0);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0003);
        wait_busy(1'h1, 8);
        // mid-conversion: ready low, old value still shown
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h0010);
        wait_busy(1'h0, CONV_N);
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h015A);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0001);
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h0100);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0000);
        check_bit(converterClkOn, 1'h0);
        check_bit(converterOn, 1'h0);
        $display("test_conversion done");
    endtask

    task automatic test_abort();
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0007);
        detCode <= 8'h21;
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0003);
        wait_busy(1'h1, 8);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0001);
        wait_busy(1'h0, 4);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0003);
        // aborted run: ready stays low, previous code kept
        read_expect(det_trim_pkg::ADDR_CONV_RESULT, 16'h005A);
        wr(det_trim_pkg::ADDR_CONV_CTRL, 16'h0008);
        check_bit(det_voltage_pin, 1'h1);
        wr(det_trim_pkg::ADDR_POWER_CTRL, 16'h0157);
        check_bit(det_voltage_pin, 1'h0);
        $display("test_abort done");
    endtask

    // counts, verdict, end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        rst = 1'h1;
        detCode = 8'h00;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        repeat (2) @(posedge clk);
        test_reset();
        test_trims();
        test_conversion();
        test_abort();
        final_report();
    end
endmodule

// ### tb/serial_host_model.sv
// ************************************************************
// host controller on the 4-wire serial port
// ************************************************************
module serial_host_model (
    // clock
    input wire logic clk,
    // serial pins toward the device
    output logic sclk,
    output logic sdin,
    output logic senN,
    input wire logic sdtoOut,
    input wire logic sdtoOe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic lastBit; // last level the device drove
    logic sdtoLine; // level the host sees on the line

    // a released line shows the inverse of its last value, never a copy
    always_comb sdtoLine = sdtoOe ? sdtoOut : ~lastBit;

    // remember the driven level while the device owns the line
    always @(posedge clk) if (sdtoOe) lastBit <= sdtoOut;

    // idle: deselected, clock parked low
    initial begin
        sclk = 1'h0;
        sdin = 1'h0;
        senN = 1'h1;
        lastBit = 1'h0;
    end

    // one whole frame; low phase 2 clocks, high phase 3 clocks, both at
    // or above the 2-clock minimum the address decode needs
    task automatic frame(input logic [23:0] f, output logic [23:0] s);
        s = 24'h00_0000;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk);
            senN <= 1'h0;
            sclk <= 1'h0;
            sdin <= f[i]; // flag, address, data, parity, msb first
            repeat (2) @(posedge clk);
            sclk <= 1'h1;
            repeat (2) @(posedge clk);
            // sample late in the high phase, where the out bit is settled
            @(negedge clk);
            s = {s[22:0], sdtoLine};
        end
        @(posedge clk);
        senN <= 1'h1;
        sclk <= 1'h0;
        sdin <= ~sdin; // data line not held between frames
        repeat (3) @(posedge clk);
    endtask

    // write with odd parity over every bit sent
    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        logic [23:0] s;
        frame({1'h0, a, d, ~^{1'h0, a, d}}, s);
    endtask

    // read: data and parity come back on the out line
    task automatic read_reg(input logic [5:0] a, output logic [15:0] d,
                            output logic p);
        logic [23:0] s;
        frame({1'h1, a, 17'h0_0000}, s);
        d = s[16:1];
        p = s[0];
    endtask
endmodule
